// [src/ssm_pkg.sv]
package ssm_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000; // System clock rate
  localparam int unsigned WAKE_SRC_HZ = 1000; // Self-clocked wake source, about 1 kHz
  localparam int unsigned WAKE_PRE_CYC = CLK_HZ / WAKE_SRC_HZ; // Clock cycles per wake tick
  localparam int unsigned SYNC_STAGES = 2; // Flops on every pin input

  // ----------------------------------------------------------------
  // Stop depth encoding (reported on stop_mode_out)
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_RUN = 2'h0;
  localparam logic [1:0] MODE_STOP1 = 2'h1;
  localparam logic [1:0] MODE_STOP2 = 2'h2;
  localparam logic [1:0] MODE_STOP3 = 2'h3;

  // ----------------------------------------------------------------
  // Wake vector selector
  // ----------------------------------------------------------------
  localparam logic [1:0] VEC_RESET = 2'h0;
  localparam logic [1:0] VEC_EXT_IRQ = 2'h1;
  localparam logic [1:0] VEC_KEYPAD = 2'h2;
  localparam logic [1:0] VEC_WAKE_TIMER = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_PDF = 1'b0; // Partial-down flag after reset
  localparam logic RST_LATCH = 1'b0; // Pin latches open after reset
  localparam logic [2:0] WAKE_RATE_OFF = 3'h0; // Wake timer and its source disabled

  // Sequencer states
  typedef enum logic [2:0] {
    SSM_RUN,
    SSM_STOP1,
    SSM_STOP2,
    SSM_STOP3
  } ssm_state_e;

  // Power and clock controls driven to the rest of the chip
  typedef struct packed {
    logic clocks_halt; // All internal clocks stopped
    logic debug_clk_keep; // Debug logic keeps its clock
    logic clock_gen_run; // Clock generator stays running
    logic clock_gen_standby; // Clock generator in standby
    logic clock_gen_off; // Clock generator off
    logic regulator_active; // Regulator at full regulation
    logic core_power_off; // Core, peripherals, flash unpowered
    logic ram_power_off; // RAM unpowered
    logic lowv_assert; // Low-voltage indication forced
  } ssm_pwr_s;
endpackage

// [src/ssm_stop_mode_sequencer.sv]
`timescale 1ns/100ps
// Behaviour
// - Stop without stop_allow forces illegal-opcode reset
// - Every stop mode halts internal clocks
// - Depth chosen from power-down and partial-down bits
// - Low-voltage in stop demotes to stop3, regulator on
// - Debug allow demotes to stop3, keeps debug clocks
// - Low-voltage in stop without debug allow: regulator on, clock-gen standby
// - External interrupt active low in stop1 and stop2
// - Stop1 asserts low-voltage; exit waits rising supply
// - Stop1 exits by reset or irq as power-on
// - Stop2 latches pins until acknowledge written
// - Stop2 exits reset, irq, timer; RAM only
// - Stop2 wake restarts as power-on, pins stay
// - Stop2 wake sets flag until acknowledge
// - Opened pins follow port or enabled peripheral
// - Stop3 halts internal clocks, retains all state
// - Stop3 exit picks reset or matching vector
// - Wake timer on 1 kHz source, off when zero
// - Status memory commands in stop return error
// - Background command wakes into debug mode
module ssm_stop_mode_sequencer
  import ssm_pkg::*;
#(
  parameter int unsigned NPINS = 8, // Number of I/O pins handled
  parameter int unsigned PRE_CYC = WAKE_PRE_CYC // Clock cycles per wake tick
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic stop_insn_in, // Stop instruction executed, pulse
  input wire logic stop_allow_in,
  input wire logic power_down_sel_in,
  input wire logic partial_down_sel_in,
  input wire logic lowv_detect_on_in,
  input wire logic lowv_detect_in_stop_in,
  input wire logic debug_entry_allow_in,
  input wire logic [2:0] wake_rate_sel_in,
  input wire logic partial_down_ack_in, // Software writes 1, pulse
  input wire logic ext_irq_high_in, // Programmed polarity, 1 = active high
  input wire logic debug_bg_cmd_in, // Background command received, pulse
  input wire logic debug_mem_status_cmd_in, // Memory-with-status command, pulse
  input wire logic reset_pin_n_in, // Pin, asynchronous
  input wire logic ext_irq_pin_in, // Pin, asynchronous
  input wire logic keypad_wake_in, // Pin, asynchronous, high = wake
  input wire logic lowv_detector_in, // Pin, asynchronous, high = supply low
  input wire logic [NPINS-1:0] port_val_in, // Port register drive values
  input wire logic [NPINS-1:0] periph_val_in, // Peripheral drive values
  input wire logic [NPINS-1:0] periph_en_in, // Peripheral owns the pin
  output logic illegal_op_rst_out, // Pulse
  output logic por_restart_out, // Pulse, power-on style restart
  output logic wake_valid_out, // Pulse, wake_vector_out valid
  output logic [1:0] wake_vector_out,
  output logic [1:0] stop_mode_out,
  output ssm_pwr_s pwr_ctl_out,
  output logic pin_latch_out, // Pins frozen at the pad
  output logic [NPINS-1:0] pin_val_out,
  output logic partial_down_flag_out,
  output logic wake_timer_run_out,
  output logic periodic_wake_irq_out, // Pulse per wake period
  output logic debug_mem_err_out, // Pulse, stop or wait error status
  output logic debug_mode_enter_out // Pulse
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NPINS < 1 || PRE_CYC < 2) begin : g_bad_param
    $error("NPINS must be at least 1 and PRE_CYC at least 2");
  end
  localparam int PRE_W = $clog2(PRE_CYC); // Prescaler width

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_meta_r; // First stage, read only by second stage
  logic [3:0] pin_sync_r; // Second stage, safe to use
  logic rst_pin_act; // Reset pin asserted
  logic irq_raw; // Synchronised irq pin level
  logic kbd_act; // Keypad wake asserted
  logic lowv_act; // Supply still below threshold

  // Every pin input is caught by two flops before the FSM sees it
  always_ff @(posedge mclk_in) begin
    pin_meta_r <= {lowv_detector_in, keypad_wake_in, ext_irq_pin_in, reset_pin_n_in};
    pin_sync_r <= pin_meta_r;
  end
  assign rst_pin_act = ~pin_sync_r[0];
  assign irq_raw = pin_sync_r[1];
  assign kbd_act = pin_sync_r[2];
  assign lowv_act = pin_sync_r[3];

  // ----------------------------------------------------------------
  // Periodic wake timer
  // ----------------------------------------------------------------
  logic [PRE_W-1:0] pre_cnt_r; // Divides clock down to the wake source
  logic [7:0] tick_cnt_r; // Counts wake source ticks
  logic [7:0] tick_limit; // Ticks per wake period
  logic tick; // One wake-source tick
  logic timer_on; // Rate field non-zero
  assign timer_on = (wake_rate_sel_in != WAKE_RATE_OFF);
  assign tick = timer_on && (pre_cnt_r == PRE_W'(PRE_CYC - 1));
  // Period doubles with each step of the rate field
  assign tick_limit = 8'(8'h01 << wake_rate_sel_in);

  // Source held in reset while disabled, so it burns nothing and never fires
  always_ff @(posedge mclk_in) begin
    if (rst_in || !timer_on) begin
      pre_cnt_r <= '0;
      tick_cnt_r <= '0;
      periodic_wake_irq_out <= 1'b0;
    end else begin
      periodic_wake_irq_out <= 1'b0;
      if (tick) begin
        pre_cnt_r <= '0;
        if (tick_cnt_r >= tick_limit - 8'h01) begin
          tick_cnt_r <= '0;
          periodic_wake_irq_out <= 1'b1;
        end else begin
          tick_cnt_r <= tick_cnt_r + 8'h01;
        end
      end else begin
        pre_cnt_r <= pre_cnt_r + PRE_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Stop depth selection and state machine
  // ----------------------------------------------------------------
  ssm_state_e state_r;
  ssm_state_e state_nxt;
  logic lvd_stop; // Low-voltage detector enabled for stop
  logic keep_dbg_r; // Debug allow seen at entry
  logic keep_lvd_r; // Low-voltage in stop seen at entry
  logic irq_act; // External irq asserted under current mode
  logic wake; // Some wake source fires in current state
  logic [1:0] vec_nxt; // Vector chosen for that wake
  logic por_nxt; // Wake restarts as power-on
  assign lvd_stop = lowv_detect_on_in && lowv_detect_in_stop_in;

  // Deep modes ignore the programmed polarity: the pin is always active low
  assign irq_act = (state_r == SSM_STOP1 || state_r == SSM_STOP2) ? ~irq_raw
                 : (ext_irq_high_in ? irq_raw : ~irq_raw);

  always_comb begin
    state_nxt = state_r;
    wake = 1'b0;
    vec_nxt = VEC_RESET;
    por_nxt = 1'b0;
    case (state_r)
      SSM_RUN: begin
        if (stop_insn_in && stop_allow_in) begin
          if (!power_down_sel_in || lvd_stop || debug_entry_allow_in) begin
            state_nxt = SSM_STOP3;
          end else if (partial_down_sel_in) begin
            state_nxt = SSM_STOP2;
          end else begin
            state_nxt = SSM_STOP1;
          end
        end
      end
      SSM_STOP1: begin
        // Supply must have recovered before the core is let go
        if ((rst_pin_act || irq_act) && !lowv_act) begin
          wake = 1'b1;
          por_nxt = 1'b1;
        end
      end
      SSM_STOP2: begin
        if (rst_pin_act || irq_act || periodic_wake_irq_out) begin
          wake = 1'b1;
          por_nxt = 1'b1;
        end
      end
      SSM_STOP3: begin
        if (rst_pin_act) begin
          wake = 1'b1;
          por_nxt = 1'b1;
        end else if (irq_act) begin
          wake = 1'b1;
          vec_nxt = VEC_EXT_IRQ;
        end else if (kbd_act) begin
          wake = 1'b1;
          vec_nxt = VEC_KEYPAD;
        end else if (periodic_wake_irq_out) begin
          wake = 1'b1;
          vec_nxt = VEC_WAKE_TIMER;
        end
      end
      default: begin
        state_nxt = SSM_RUN;
      end
    endcase
    // A wake, or a background command leaving stop straight into debug mode
    if (wake || (state_r != SSM_RUN && keep_dbg_r && debug_bg_cmd_in)) begin
      state_nxt = SSM_RUN;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_r <= SSM_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Entry options are frozen so software cannot change a stop in progress
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      keep_dbg_r <= 1'b0;
      keep_lvd_r <= 1'b0;
    end else if (state_r == SSM_RUN && stop_insn_in && stop_allow_in) begin
      keep_dbg_r <= debug_entry_allow_in;
      keep_lvd_r <= lvd_stop;
    end
  end

  // ----------------------------------------------------------------
  // Event pulses
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      illegal_op_rst_out <= 1'b0;
      por_restart_out <= 1'b0;
      wake_valid_out <= 1'b0;
      wake_vector_out <= VEC_RESET;
      debug_mem_err_out <= 1'b0;
      debug_mode_enter_out <= 1'b0;
      wake_timer_run_out <= 1'b0;
    end else begin
      illegal_op_rst_out <= (state_r == SSM_RUN) && stop_insn_in && !stop_allow_in;
      por_restart_out <= wake && por_nxt;
      wake_valid_out <= wake;
      wake_timer_run_out <= timer_on;
      if (wake) begin
        wake_vector_out <= vec_nxt;
      end
      // Memory is never touched while stopped, only an error comes back
      debug_mem_err_out <= (state_r != SSM_RUN) && debug_mem_status_cmd_in;
      debug_mode_enter_out <= (state_r != SSM_RUN) && keep_dbg_r && debug_bg_cmd_in;
    end
  end

  // ----------------------------------------------------------------
  // Power and clock controls
  // ----------------------------------------------------------------
  // Driven from the next state so controls change on the entry edge itself
  always_ff @(posedge mclk_in) begin
    pwr_ctl_out <= '0;
    pwr_ctl_out.clock_gen_run <= 1'b1;
    pwr_ctl_out.regulator_active <= 1'b1;
    stop_mode_out <= MODE_RUN;
    case (rst_in ? SSM_RUN : state_nxt) // Reset keeps the run defaults
      SSM_STOP1: begin
        stop_mode_out <= MODE_STOP1;
        pwr_ctl_out.clocks_halt <= 1'b1;
        pwr_ctl_out.clock_gen_run <= 1'b0;
        pwr_ctl_out.clock_gen_off <= 1'b1;
        pwr_ctl_out.regulator_active <= 1'b0;
        pwr_ctl_out.core_power_off <= 1'b1;
        pwr_ctl_out.ram_power_off <= 1'b1;
        pwr_ctl_out.lowv_assert <= 1'b1;
      end
      SSM_STOP2: begin
        stop_mode_out <= MODE_STOP2;
        pwr_ctl_out.clocks_halt <= 1'b1;
        pwr_ctl_out.clock_gen_run <= 1'b0;
        pwr_ctl_out.clock_gen_off <= 1'b1;
        pwr_ctl_out.regulator_active <= 1'b0;
        pwr_ctl_out.core_power_off <= 1'b1;
      end
      SSM_STOP3: begin
        stop_mode_out <= MODE_STOP3;
        pwr_ctl_out.clocks_halt <= 1'b1;
        // Kept options load on the entry edge itself, so that edge uses the live ones
        if (state_r == SSM_RUN ? debug_entry_allow_in : keep_dbg_r) begin
          pwr_ctl_out.debug_clk_keep <= 1'b1;
        end else if (state_r == SSM_RUN ? lvd_stop : keep_lvd_r) begin
          pwr_ctl_out.clock_gen_run <= 1'b0;
          pwr_ctl_out.clock_gen_standby <= 1'b1;
        end else begin
          pwr_ctl_out.clock_gen_run <= 1'b0;
          pwr_ctl_out.clock_gen_off <= 1'b1;
          pwr_ctl_out.regulator_active <= 1'b0;
        end
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Pin latches and partial-down flag
  // ----------------------------------------------------------------
  logic entering_stop2; // First edge into stop2
  logic stop2_woke; // Stop2 wake taken this cycle
  assign entering_stop2 = (state_r == SSM_RUN) && (state_nxt == SSM_STOP2);
  assign stop2_woke = (state_r == SSM_STOP2) && (state_nxt == SSM_RUN);

  // Latch survives the restart; only the acknowledge opens it
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pin_latch_out <= RST_LATCH;
    end else if (entering_stop2) begin
      pin_latch_out <= 1'b1;
    end else if (partial_down_ack_in && state_r == SSM_RUN) begin
      pin_latch_out <= 1'b0;
    end
  end

  // Set wins over a same-cycle acknowledge so a wake is never missed
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      partial_down_flag_out <= RST_PDF;
    end else if (stop2_woke) begin
      partial_down_flag_out <= 1'b1;
    end else if (partial_down_ack_in) begin
      partial_down_flag_out <= 1'b0;
    end
  end

  // Software must restore ports before the ack, or pins fall to reset values
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pin_val_out <= '0;
    end else if (state_nxt == SSM_STOP1) begin
      pin_val_out <= '0;
    end else if (!pin_latch_out && !entering_stop2) begin
      pin_val_out <= (periph_en_in & periph_val_in) | (~periph_en_in & port_val_in);
    end
  end

endmodule

// [test/ssm_chk.sv]
`timescale 1ns/100ps
module ssm_chk
  import ssm_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic stop_insn_in,
  input wire logic stop_allow_in,
  input wire logic power_down_sel_in,
  input wire logic partial_down_sel_in,
  input wire logic lowv_detect_on_in,
  input wire logic lowv_detect_in_stop_in,
  input wire logic debug_entry_allow_in,
  input wire logic partial_down_ack_in,
  input wire logic debug_mem_status_cmd_in,
  input wire logic [2:0] wake_rate_sel_in,
  input wire logic illegal_op_rst_out,
  input wire logic por_restart_out,
  input wire logic wake_valid_out,
  input wire logic [1:0] stop_mode_out,
  input wire ssm_pwr_s pwr_ctl_out,
  input wire logic pin_latch_out,
  input wire logic partial_down_flag_out,
  input wire logic wake_timer_run_out,
  input wire logic debug_mem_err_out
);
  // --------
  // Helpers
  // --------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic enter; // Stop accepted this cycle
  logic lvs; // Detector kept alive through stop
  assign enter = stop_insn_in && stop_allow_in && (stop_mode_out == MODE_RUN);
  assign lvs = lowv_detect_on_in && lowv_detect_in_stop_in;
  // Wake out of stop2 takes two steps: in stop2, then back in run
  sequence s_left_stop2;
    stop_mode_out == MODE_STOP2 ##1 stop_mode_out == MODE_RUN;
  endsequence
  // --------
  // Checks
  // --------
  AST_NO_ALLOW: assert property (stop_insn_in && !stop_allow_in && stop_mode_out == MODE_RUN
    |-> ##1 (stop_mode_out == MODE_RUN) ##[0:1] illegal_op_rst_out) else $error("stop taken");
  AST_HALT: assert property (stop_mode_out != MODE_RUN |-> pwr_ctl_out.clocks_halt)
    else $error("clocks run in stop");
  AST_DEPTH: assert property (enter && !debug_entry_allow_in && !lvs |=> stop_mode_out ==
    (!$past(power_down_sel_in) ? MODE_STOP3 : $past(partial_down_sel_in) ? MODE_STOP2 :
    MODE_STOP1)) else $error("wrong stop depth");
  AST_DBG_S3: assert property (enter && debug_entry_allow_in |=> stop_mode_out == MODE_STOP3
    && pwr_ctl_out.debug_clk_keep && pwr_ctl_out.clock_gen_run && pwr_ctl_out.regulator_active)
    else $error("debug stop wrong");
  AST_LV_S3: assert property (enter && lvs && !debug_entry_allow_in |=>
    stop_mode_out == MODE_STOP3 && pwr_ctl_out.clock_gen_standby && pwr_ctl_out.regulator_active)
    else $error("low-voltage stop wrong");
  AST_S1_LOWV: assert property (stop_mode_out == MODE_STOP1 |-> pwr_ctl_out.lowv_assert)
    else $error("stop1 without low-voltage");
  AST_S2_PWR: assert property (stop_mode_out == MODE_STOP2 |-> pin_latch_out
    && pwr_ctl_out.core_power_off && !pwr_ctl_out.ram_power_off) else $error("stop2 power");
  AST_S2_WAKE: assert property (s_left_stop2 |-> por_restart_out && wake_valid_out
    && partial_down_flag_out && pin_latch_out) else $error("stop2 wake wrong");
  AST_FLAG: assert property (partial_down_flag_out && !partial_down_ack_in |=>
    partial_down_flag_out) else $error("flag dropped");
  AST_TMR_OFF: assert property ((wake_rate_sel_in == WAKE_RATE_OFF) [*3] |->
    !wake_timer_run_out) else $error("timer runs while off");
  AST_MEM_ERR: assert property (stop_mode_out != MODE_RUN && debug_mem_status_cmd_in |=>
    debug_mem_err_out) else $error("no error status");
endmodule

bind ssm_stop_mode_sequencer ssm_chk i_chk (.mclk_in, .rst_in, .stop_insn_in, .stop_allow_in,
  .power_down_sel_in, .partial_down_sel_in, .lowv_detect_on_in, .lowv_detect_in_stop_in,
  .debug_entry_allow_in, .partial_down_ack_in, .debug_mem_status_cmd_in, .wake_rate_sel_in,
  .illegal_op_rst_out, .por_restart_out, .wake_valid_out, .stop_mode_out, .pwr_ctl_out,
  .pin_latch_out, .partial_down_flag_out, .wake_timer_run_out, .debug_mem_err_out);

// [test/ssm_cpu_model.sv]
`timescale 1ns/100ps
module ssm_cpu_model
  import ssm_pkg::*;
#(
  parameter int unsigned NPINS = 8 // Pins handled
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic stop_req_in, // Execute a stop, pulse
  input wire logic ack_req_in, // Restore ports then acknowledge, pulse
  input wire logic [NPINS-1:0] saved_in, // Port image kept in RAM
  input wire logic por_restart_in, // Restart seen, registers cleared
  output logic stop_insn_out,
  output logic partial_down_ack_out,
  output logic [NPINS-1:0] port_val_out
);
  logic ack_pend_r; // Restore done, acknowledge follows
  // Stop instruction lasts one cycle
  always_ff @(posedge mclk_in) begin
    stop_insn_out <= stop_req_in && !rst_in;
  end
  // Port registers lose their value on a restart, so they are restored from RAM first
  always_ff @(posedge mclk_in) begin
    if (rst_in || por_restart_in) begin
      port_val_out <= '0;
    end else if (ack_req_in) begin
      port_val_out <= saved_in;
    end
  end
  // Acknowledge one cycle after the restore, never with it
  always_ff @(posedge mclk_in) begin
    ack_pend_r <= ack_req_in && !rst_in;
    partial_down_ack_out <= ack_pend_r && !rst_in;
  end
endmodule

// [test/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import ssm_pkg::*;
  logic mclk_in = 1'b0, rst_in = 1'b1, stop_req = 1'b0, ack_req = 1'b0, stop_insn, ack;
  logic allow = 1'b1, pd = 1'b0, ppd = 1'b0, lowv_detect_on = 1'b0, lowv_detect_in_stop = 1'b1, dbg = 1'b0;
  logic irq_hi = 1'b0, bg = 1'b0, mem = 1'b0, rpin_n = 1'b1, irq = 1'b1, kpad = 1'b0;
  logic lowv = 1'b0, illeg, por, wv, latch, flag, trun, pwi, merr, dme;
  logic [2:0] rate = 3'h0;
  logic [7:0] saved = 8'h00, pval, per_v = 8'h0a, per_en = 8'h0f, pins;
  logic [1:0] vec, mode;
  logic [1:0] vecs [4] = '{VEC_RESET, VEC_EXT_IRQ, VEC_KEYPAD, VEC_WAKE_TIMER};
  ssm_pwr_s pwr;
  int n_fail = 0, n_compared = 0, cycles = 0;
  int n_pwi = 0; // Wake timer pulses seen
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end
  ssm_cpu_model #(.NPINS(8)) i_cpu (.mclk_in(mclk_in), .rst_in(rst_in), .stop_req_in(stop_req),
    .ack_req_in(ack_req), .saved_in(saved), .por_restart_in(por), .stop_insn_out(stop_insn),
    .partial_down_ack_out(ack), .port_val_out(pval));
  // Short wake tick keeps timer periods at a few cycles
  ssm_stop_mode_sequencer #(.NPINS(8), .PRE_CYC(4)) i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .stop_insn_in(stop_insn), .stop_allow_in(allow), .power_down_sel_in(pd),
    .partial_down_sel_in(ppd), .lowv_detect_on_in(lowv_detect_on), .lowv_detect_in_stop_in(lowv_detect_in_stop),
    .debug_entry_allow_in(dbg), .wake_rate_sel_in(rate), .partial_down_ack_in(ack),
    .ext_irq_high_in(irq_hi), .debug_bg_cmd_in(bg), .debug_mem_status_cmd_in(mem),
    .reset_pin_n_in(rpin_n), .ext_irq_pin_in(irq), .keypad_wake_in(kpad),
    .lowv_detector_in(lowv), .port_val_in(pval), .periph_val_in(per_v), .periph_en_in(per_en),
    .illegal_op_rst_out(illeg), .por_restart_out(por), .wake_valid_out(wv),
    .wake_vector_out(vec), .stop_mode_out(mode), .pwr_ctl_out(pwr), .pin_latch_out(latch),
    .pin_val_out(pins), .partial_down_flag_out(flag), .wake_timer_run_out(trun),
    .periodic_wake_irq_out(pwi), .debug_mem_err_out(merr), .debug_mode_enter_out(dme));
  // --------
  // Helpers
  // --------
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic look(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  // Config {allow, power-down, partial-down, low-voltage, debug, irq polarity} set with the stop
  task automatic stop_now(input logic [5:0] cfg);
    @(posedge mclk_in);
    {allow, pd, ppd, lowv_detect_on, dbg, irq_hi} <= cfg;
    stop_req <= 1'b1;
    @(posedge mclk_in);
    stop_req <= 1'b0;
    look(2);
  endtask
  task automatic ack_now(input logic [7:0] img);
    @(posedge mclk_in);
    saved <= img;
    ack_req <= 1'b1;
    @(posedge mclk_in);
    ack_req <= 1'b0;
    look(4);
  endtask
  // Bounded wait: synchroniser plus timer period fit well inside 40 cycles
  task automatic wait_wake;
    int k;
    k = 0;
    do begin
      @(negedge mclk_in);
      k++;
    end while (wv !== 1'b1 && k < 40);
    chk_val(wv, 1'b1);
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // --------
  // Scenarios
  // --------
  task automatic t_illegal;
    stop_now(6'b010000);
    chk_val(illeg, 1'b1);
    chk_val(mode, MODE_RUN);
  endtask
  // Pin held high with high polarity must not wake stop2; low must
  task automatic t_stop2;
    ack_now(8'ha5);
    stop_now(6'b111001);
    chk_val(mode, MODE_STOP2);
    chk_val(pins, 8'haa);
    look(10);
    chk_val(mode, MODE_STOP2);
    @(posedge mclk_in);
    irq <= 1'b0;
    wait_wake;
    chk_val(vec, VEC_RESET);
    chk_val({por, flag}, 2'h3);
    @(posedge mclk_in);
    irq <= 1'b1;
    look(3);
    chk_val(pins, 8'haa);
    ack_now(8'h3c);
    chk_val({latch, flag}, 2'h0);
    chk_val(pins, 8'h3a);
  endtask
  task automatic t_stop1;
    @(posedge mclk_in);
    lowv <= 1'b1;
    stop_now(6'b110000);
    chk_val(mode, MODE_STOP1);
    chk_val(pins, 8'h00);
    @(posedge mclk_in);
    irq <= 1'b0;
    look(10);
    chk_val(mode, MODE_STOP1);
    @(posedge mclk_in);
    lowv <= 1'b0;
    wait_wake;
    chk_val({vec, por}, {VEC_RESET, 1'b1});
    @(posedge mclk_in);
    irq <= 1'b1;
  endtask
  task automatic t_stop3;
    for (int i = 0; i < 4; i++) begin
      stop_now(6'b100000);
      look(12);
      chk_val(mode, MODE_STOP3);
      @(posedge mclk_in);
      case (i)
        0: rpin_n <= 1'b0;
        1: irq <= 1'b0;
        2: kpad <= 1'b1;
        default: rate <= 3'h1;
      endcase
      wait_wake;
      chk_val(vec, vecs[i]);
      if (i == 3) chk_val(trun, 1'b1);
      if (i == 3) chk_val(8'(n_pwi), 8'h01);
      @(posedge mclk_in);
      {rpin_n, irq, kpad, rate} <= {1'b1, 1'b1, 1'b0, 3'h0};
      look(3);
    end
  endtask
  task automatic t_debug;
    stop_now(6'b111010);
    chk_val({mode, pwr.debug_clk_keep}, {MODE_STOP3, 1'b1});
    @(posedge mclk_in);
    mem <= 1'b1;
    @(posedge mclk_in);
    mem <= 1'b0;
    look(1);
    chk_val(merr, 1'b1);
    @(posedge mclk_in);
    bg <= 1'b1;
    @(posedge mclk_in);
    bg <= 1'b0;
    look(1);
    chk_val({dme, mode}, {1'b1, MODE_RUN});
  endtask
  task automatic t_lowv;
    stop_now(6'b110100);
    chk_val(mode, MODE_STOP3);
    chk_val({pwr.clock_gen_standby, pwr.regulator_active}, 2'h3);
    @(posedge mclk_in);
    rpin_n <= 1'b0;
    wait_wake;
    @(posedge mclk_in);
    rpin_n <= 1'b1;
  endtask
  // Wake timer pulses, counted away from the edge that launches them
  always @(negedge mclk_in) begin
    if (pwi === 1'b1) n_pwi++;
  end
  // Hang guard: whole run needs well under a thousand cycles
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      end_of_test;
    end
  end
  initial begin
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    look(4);
    chk_val({mode, pwr.clock_gen_run, flag, latch}, {MODE_RUN, 3'h4});
    t_illegal;
    t_stop2;
    t_stop1;
    t_stop3;
    t_debug;
    t_lowv;
    end_of_test;
  end
endmodule
